// ### src/rss_pkg.sv
// package for the rail strobe slot assignment block: register map, field layout,
// reset values, gap timing and the slot carrier struct
// assumes a 200 MHz core clock
package rss_pkg;

    localparam logic [7:0] ADDR_BB_B3_SLOT = 8'h23;
    localparam logic [7:0] ADDR_RSV_SLOT   = 8'h24;
    localparam logic [7:0] ADDR_LIN_SLOT   = 8'h25;

    localparam logic [7:0] RST_BB_B3_SLOT  = 8'h75;
    localparam logic [7:0] RST_RSV_SLOT    = 8'h12;
    localparam logic [7:0] RST_LIN_SLOT    = 8'h63;

    // field positions (high nibble / low nibble)
    localparam int         HI_NIB_LSB      = 4;
    localparam int         LO_NIB_LSB      = 0;
    // writable bits of the mixed register, the rest read zero
    localparam logic [7:0] RSV_WR_MASK     = 8'h33;

    localparam logic [3:0] SLOT_MIN        = 4'h3;
    localparam logic [3:0] SLOT_MAX        = 4'ha;
    localparam logic [3:0] STROBE_FIRST    = 4'h1;
    localparam logic [3:0] STROBE_LAST     = 4'ha;
    localparam int         NUM_GAPS        = 9;
    localparam int         NUM_RAILS       = 3;

    localparam int         CLK_MHZ         = 200;
    localparam int         GAP_SHORT_US    = 2000;
    localparam int         GAP_LONG_US     = 5000;
    localparam int         PD_FACTOR       = 10;
    localparam int         GAP_SHORT_CYC   = GAP_SHORT_US * CLK_MHZ;
    localparam int         GAP_LONG_CYC    = GAP_LONG_US * CLK_MHZ;
    localparam int         CNT_W           = 24;

    typedef struct packed {
        logic [3:0] buckboost_slot_field;
        logic [3:0] buck3_slot_field;
        logic [3:0] linear_rail_slot_field;
    } rss_slots_s;

    typedef enum logic [1:0] {
        RSS_IDLE,
        RSS_STROBE,
        RSS_WAIT
    } rss_state_e;

endpackage

// ### src/rss_gap_timer.sv
// down counter that times one inter-strobe gap
// load and length come from the sequencer on the same clock
`timescale 1ns/1ps
module rss_gap_timer #(
    parameter int W = 24
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] len_i,
    output logic              done_o
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_q <= '0;
        else if (load_i)
            cnt_q <= len_i;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - W'(1);
    end

    // a gap of len cycles ends len cycles after the load
    assign done_o = (cnt_q == W'(1)) && !load_i;
endmodule

// ### src/rss_top.sv
// rail strobe slot registers and the strobe sequencer that drives the rail enables
// registers are reached over a plain subaddress port from the serial host logic;
// unlock, gap delay selects and delay factor come from neighbouring logic on clk_i
//
// Overview of operation
// - slot values 3h to Ah enable the rail at strobe 3 to 10
// - slot values 0h to 2h and Bh to Fh leave the rail unsequenced
// - 0x23 holds buck-boost slot high nibble reset 7h, buck3 low reset 5h
// - 0x25 holds linear slot low nibble reset 3h, reserved high nibble 6h
// - 0x24 bits 7-6, 3-2 read zero; 5-4 reset 1h, 1-0 reset 2h
// - each of nine gaps waits 2 ms or 5 ms by its select bit
// - delay factor bit stretches power-down gaps tenfold, power-up unchanged
`timescale 1ns/1ps
module rss_top #(
    parameter int SHORT_CYC = rss_pkg::GAP_SHORT_CYC,
    parameter int LONG_CYC  = rss_pkg::GAP_LONG_CYC
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          reg_wr_i,
    input  wire logic [7:0]                    reg_addr_i,
    input  wire logic [7:0]                    reg_wdata_i,
    output logic      [7:0]                    reg_rdata_o,
    input  wire logic                          unlock_i,
    input  wire logic [rss_pkg::NUM_GAPS-1:0]  gap_delay_select_i,
    input  wire logic                          powerdown_delay_factor_i,
    input  wire logic                          pu_start_i,
    input  wire logic                          pd_start_i,
    output logic      [rss_pkg::NUM_RAILS-1:0] rail_en_o,
    output logic      [3:0]                    strobe_o,
    output logic                               busy_o,
    output logic                               unlocked_o
);
    localparam int W = rss_pkg::CNT_W;

    // 1 = slot value n fires on strobe n; only 3h..Ah can match
    function automatic logic slot_hit(input logic [3:0] slot, input logic [3:0] n);
        slot_hit = (slot >= rss_pkg::SLOT_MIN) && (slot <= rss_pkg::SLOT_MAX)
                   && (slot == n);
    endfunction

    logic [7:0]              bb_b3_q;
    logic [7:0]              rsv_q;
    logic [7:0]              lin_q;
    logic                    unlocked_q;
    logic                    wr_ok;
    rss_pkg::rss_slots_s     slots;
    rss_pkg::rss_state_e     state_q;
    logic [3:0]              strobe_q;
    logic                    down_q;
    logic [rss_pkg::NUM_RAILS-1:0] hits;
    logic [W-1:0]            gap_len;
    logic                    gap_load;
    logic                    gap_done;
    logic                    gap_sel;
    logic [3:0]              gap_idx;

    assign wr_ok = reg_wr_i && unlocked_q;

    // unlock is consumed by any protected write; a fresh unlock in the same cycle wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            unlocked_q <= 1'b0;
        else if (unlock_i)
            unlocked_q <= 1'b1;
        else if (reg_wr_i && (reg_addr_i == rss_pkg::ADDR_BB_B3_SLOT
                 || reg_addr_i == rss_pkg::ADDR_RSV_SLOT
                 || reg_addr_i == rss_pkg::ADDR_LIN_SLOT))
            unlocked_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bb_b3_q <= rss_pkg::RST_BB_B3_SLOT;
            rsv_q   <= rss_pkg::RST_RSV_SLOT;
            lin_q   <= rss_pkg::RST_LIN_SLOT;
        end
        else if (wr_ok)
        begin
            if (reg_addr_i == rss_pkg::ADDR_BB_B3_SLOT)
                bb_b3_q <= reg_wdata_i;
            if (reg_addr_i == rss_pkg::ADDR_RSV_SLOT)
                rsv_q <= reg_wdata_i & rss_pkg::RSV_WR_MASK;
            if (reg_addr_i == rss_pkg::ADDR_LIN_SLOT)
                lin_q <= reg_wdata_i;
        end
    end

    // read data registered one cycle after the address; unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            reg_rdata_o <= 8'h00;
        else
            unique case (reg_addr_i)
                rss_pkg::ADDR_BB_B3_SLOT: reg_rdata_o <= bb_b3_q;
                rss_pkg::ADDR_RSV_SLOT:   reg_rdata_o <= rsv_q & rss_pkg::RSV_WR_MASK;
                rss_pkg::ADDR_LIN_SLOT:   reg_rdata_o <= lin_q;
                default:                  reg_rdata_o <= 8'h00;
            endcase
    end

    assign slots.buckboost_slot_field   = bb_b3_q[rss_pkg::HI_NIB_LSB +: 4];
    assign slots.buck3_slot_field       = bb_b3_q[rss_pkg::LO_NIB_LSB +: 4];
    assign slots.linear_rail_slot_field = lin_q[rss_pkg::LO_NIB_LSB +: 4];

    assign hits[0] = slot_hit(slots.buckboost_slot_field, strobe_q);
    assign hits[1] = slot_hit(slots.buck3_slot_field, strobe_q);
    assign hits[2] = slot_hit(slots.linear_rail_slot_field, strobe_q);

    // gap after strobe n going up uses select n-1; going down, the gap below n uses n-2
    assign gap_idx = down_q ? strobe_q - 4'h2 : strobe_q - 4'h1;
    // idle and the last strobe point past the select bits; no gap is loaded there
    assign gap_sel = (gap_idx < 4'(rss_pkg::NUM_GAPS)) ? gap_delay_select_i[gap_idx] : 1'b0;
    always_comb
    begin
        gap_len = gap_sel ? W'(LONG_CYC) : W'(SHORT_CYC);
        if (down_q && powerdown_delay_factor_i)
            gap_len = gap_sel ? W'(LONG_CYC * rss_pkg::PD_FACTOR)
                              : W'(SHORT_CYC * rss_pkg::PD_FACTOR);
    end

    assign gap_load = (state_q == rss_pkg::RSS_STROBE)
                      && (strobe_q != (down_q ? rss_pkg::STROBE_FIRST : rss_pkg::STROBE_LAST));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q  <= rss_pkg::RSS_IDLE;
            strobe_q <= 4'h0;
            down_q   <= 1'b0;
        end
        else
            unique case (state_q)
                rss_pkg::RSS_IDLE:
                begin
                    if (pu_start_i)
                    begin
                        state_q  <= rss_pkg::RSS_STROBE;
                        strobe_q <= rss_pkg::STROBE_FIRST;
                        down_q   <= 1'b0;
                    end
                    else if (pd_start_i)
                    begin
                        state_q  <= rss_pkg::RSS_STROBE;
                        strobe_q <= rss_pkg::STROBE_LAST;
                        down_q   <= 1'b1;
                    end
                end
                rss_pkg::RSS_STROBE:
                    state_q <= gap_load ? rss_pkg::RSS_WAIT : rss_pkg::RSS_IDLE;
                rss_pkg::RSS_WAIT:
                    if (gap_done)
                    begin
                        state_q  <= rss_pkg::RSS_STROBE;
                        strobe_q <= down_q ? strobe_q - 4'h1 : strobe_q + 4'h1;
                    end
            endcase
    end

    // rails switch on at their strobe going up and off at it going down
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rail_en_o <= '0;
        else if (state_q == rss_pkg::RSS_STROBE)
            rail_en_o <= down_q ? (rail_en_o & ~hits) : (rail_en_o | hits);
    end

    rss_gap_timer #(.W(W)) u_gap (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .load_i (gap_load),
        .len_i  (gap_len),
        .done_o (gap_done)
    );

    assign strobe_o   = (state_q == rss_pkg::RSS_STROBE) ? strobe_q : 4'h0;
    assign busy_o     = (state_q != rss_pkg::RSS_IDLE);
    assign unlocked_o = unlocked_q;

    // checks
    logic [W-1:0] wait_cnt_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || state_q != rss_pkg::RSS_WAIT)
            wait_cnt_q <= '0;
        else
            wait_cnt_q <= wait_cnt_q + W'(1);
    end

    locked_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        reg_wr_i && !unlocked_q |=> $stable(bb_b3_q) && $stable(lin_q) && $stable(rsv_q))
        else $error("locked write changed a slot register");

    unlock_consumed_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ok && !unlock_i && reg_addr_i == rss_pkg::ADDR_LIN_SLOT |=> !unlocked_q)
        else $error("unlock not consumed by protected write");

    reset_values_a: assert property (@(posedge clk_i)
        $past(rst_i) |-> bb_b3_q == 8'h75 && lin_q == 8'h63 && rsv_q == 8'h12)
        else $error("slot registers wrong after reset");

    rsv_read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        reg_addr_i == rss_pkg::ADDR_RSV_SLOT |=> (reg_rdata_o & 8'hcc) == 8'h00)
        else $error("reserved bits of 0x24 read nonzero");

    lin_write_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ok && reg_addr_i == rss_pkg::ADDR_LIN_SLOT ##1 reg_addr_i == rss_pkg::ADDR_LIN_SLOT
        |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("linear slot register did not store write");

    rail_on_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == rss_pkg::RSS_STROBE && !down_q && strobe_q == lin_q[3:0]
        && lin_q[3:0] >= 4'h3 && lin_q[3:0] <= 4'ha |=> rail_en_o[2])
        else $error("linear rail not enabled at its strobe");

    unsequenced_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (lin_q[3:0] < 4'h3 || lin_q[3:0] > 4'ha) && !rail_en_o[2]
        && $stable(lin_q) |=> !rail_en_o[2])
        else $error("unsequenced linear rail was enabled");

    gap_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == rss_pkg::RSS_WAIT && gap_done && !down_q
        |-> wait_cnt_q + W'(1) == W'(gap_sel ? LONG_CYC : SHORT_CYC))
        else $error("power-up gap length wrong");

    pd_factor_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == rss_pkg::RSS_WAIT && gap_done && down_q && powerdown_delay_factor_i
        |-> wait_cnt_q + W'(1) == W'((gap_sel ? LONG_CYC : SHORT_CYC) * rss_pkg::PD_FACTOR))
        else $error("power-down gap not stretched tenfold");
endmodule

// ### dv/rss_top_tb.sv
// self-checking bench for the rail strobe slot block: register table, locking, sequencing
// assumes the design files under src/ and short gap lengths so the run stays brief
`timescale 1ns/1ps
module rss_top_tb;
    localparam int SHORT = 4;
    localparam int LONG  = 7;
    typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } rss_row_s;
    localparam rss_row_s ROWS [7] = '{'{8'h23, 8'ha3, 8'ha3}, '{8'h23, 8'h0f, 8'h0f},
        '{8'h24, 8'hff, 8'h33}, '{8'h24, 8'hcc, 8'h00}, '{8'h25, 8'h5a, 8'h5a},
        '{8'h25, 8'ha3, 8'ha3}, '{8'h26, 8'hff, 8'h00}};

    logic       clk_i, rst_i, reg_wr_i, unlock_i, powerdown_delay_factor_i;
    logic       pu_start_i, pd_start_i, busy_o, unlocked_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [8:0] gap_delay_select_i;
    logic [2:0] rail_en_o, rails;
    logic [3:0] strobe_o;
    logic [3:0] slot [3];
    int         num_errors = 0;
    int         checks = 0;

    rss_top #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .unlock_i(unlock_i),
        .gap_delay_select_i(gap_delay_select_i),
        .powerdown_delay_factor_i(powerdown_delay_factor_i), .pu_start_i(pu_start_i),
        .pd_start_i(pd_start_i), .rail_en_o(rail_en_o), .strobe_o(strobe_o),
        .busy_o(busy_o), .unlocked_o(unlocked_o));

    always #2.5 clk_i = ~clk_i;

    task automatic conclude();
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // unlock is optional so that refused writes can be issued on purpose
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit unl);
        if (unl)
        begin
            @(posedge clk_i);
            unlock_i <= 1'b1;
            @(posedge clk_i);
            unlock_i <= 1'b0;
            #1 cmp({7'h0, unlocked_o}, 8'h01);
        end
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        @(posedge clk_i);
        #1 cmp(reg_rdata_o, e);
    endtask

    // follows one whole sequence, checking strobe order, spacing and rail enables
    task automatic run(input bit up);
        int s, n, len, b;
        @(posedge clk_i);
        if (up) pu_start_i <= 1'b1;
        else pd_start_i <= 1'b1;
        @(posedge clk_i);
        pu_start_i <= 1'b0;
        pd_start_i <= 1'b0;
        #1 cmp({7'h0, busy_o}, 8'h01);
        s = up ? 1 : 10;
        n = 0;
        len = 0;
        for (int k = 0; k < 10; k++)
        begin
            while (strobe_o === 4'h0 && n < 200)
            begin
                @(posedge clk_i);
                #1 n++;
            end
            cmp({4'h0, strobe_o}, s[7:0]);
            if (k > 0) cmp(n[7:0], len[7:0] + 8'h01);
            for (int r = 0; r < 3; r++)
                if (slot[r] == s[3:0] && s >= 3) rails[r] = up;
            b = up ? s - 1 : s - 2;
            if (k < 9) len = (gap_delay_select_i[b] ? LONG : SHORT)
                * ((!up && powerdown_delay_factor_i) ? rss_pkg::PD_FACTOR : 1);
            @(posedge clk_i);
            #1 n = 1;
            cmp({5'h0, rail_en_o}, {5'h0, rails});
            s = up ? s + 1 : s - 1;
        end
        @(posedge clk_i);
        #1 cmp({7'h0, busy_o}, 8'h00);
    endtask

    initial
    begin
        repeat (40000) @(posedge clk_i);
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end

    initial
    begin
        clk_i = 0; rst_i = 1; reg_wr_i = 0; unlock_i = 0; reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00; gap_delay_select_i = 9'h16b; powerdown_delay_factor_i = 0;
        pu_start_i = 0; pd_start_i = 0; rails = 3'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ROWS[i])
        begin
            wr(ROWS[i].a, ROWS[i].d, 1'b1);
            rd(ROWS[i].a, ROWS[i].e);
        end
        // reset in mid-sequence must drop rails and restore the table
        @(posedge clk_i) pu_start_i <= 1'b1;
        @(posedge clk_i) pu_start_i <= 1'b0;
        // linear rail sits on strobe 3, so it is already on when reset hits
        repeat (20) @(posedge clk_i);
        #1 cmp({5'h0, rail_en_o}, 8'h04);
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 cmp({busy_o, unlocked_o, rail_en_o, 3'h0}, 8'h00);
        cmp({4'h0, strobe_o}, 8'h00);
        rd(8'h23, 8'h75);
        rd(8'h24, 8'h12);
        rd(8'h25, 8'h63);
        slot = '{4'h7, 4'h5, 4'h3};
        wr(8'h25, 8'h64, 1'b1);
        wr(8'h23, 8'h11, 1'b0);
        rd(8'h25, 8'h64);
        rd(8'h23, 8'h75);
        slot[2] = 4'h4;
        // a stray stop request while powering up must be ignored
        powerdown_delay_factor_i <= 1'b1;
        fork
            begin
                repeat (20) @(posedge clk_i);
                pd_start_i <= 1'b1;
                @(posedge clk_i) pd_start_i <= 1'b0;
            end
        join_none
        run(1'b1);
        run(1'b0);
        powerdown_delay_factor_i <= 1'b0;
        for (int v = 0; v < 16; v++)
        begin
            wr(8'h25, {4'h6, v[3:0]}, 1'b1);
            slot[2] = v[3:0];
            run(1'b1);
            run(1'b0);
        end
        conclude();
    end
endmodule
